/* File: verilog/pv_programmer.sv */
// Programmer end: sequences address, data, select lines, VPP and program pulses
module pv_programmer
    import pv_pkg::*;
#(
    parameter int unsigned PULSE_CYC = PULSE_CYC_DEF
) (
    input  wire logic              CLK,
    input  wire logic              RESETN,
    pv_link_if.programmer          LINK,
    input  wire logic              CMD_VALID,
    output logic                   CMD_READY,
    input  wire pv_mode_t          CMD_MODE,
    input  wire logic [ADDR_W-1:0] CMD_ADDR,
    input  wire logic [7:0]        CMD_DATA,
    output logic                   RSP_VALID,
    output logic      [7:0]        RSP_DATA,
    output logic                   BUSY
);
    typedef enum logic [3:0] {
        P_IDLE, P_ADDR, P_DATA, P_SEL, P_VPPUP, P_LOW, P_HIGH, P_VPPDN, P_READ, P_DONE
    } pstate_t;

    typedef struct packed {
        pstate_t           st;
        logic [CNT_W-1:0]  cnt;
        logic [4:0]        pulses;
        pv_mode_t          mode;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        data;
        logic [4:0]        div;
        logic              osc;
        logic              rst_lvl;
        logic              program_store_enable_n_n;
        logic              strobe;
        vpp_level_t        vpp;
        logic [4:0]        sel;
        logic              data_oe;
        logic [7:0]        rd_s1;
        logic [7:0]        rd_s2;
        logic              rsp_valid;
        logic [7:0]        rsp_data;
    } prog_state_t;

    localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] VPPS_LD  = CNT_W'(VPP_SETUP_CYC - 1);
    localparam logic [CNT_W-1:0] VPPH_LD  = CNT_W'(VPP_HOLD_CYC - 1);
    localparam logic [CNT_W-1:0] GAP_LD   = CNT_W'(PULSE_GAP_CYC - 1);
    localparam logic [CNT_W-1:0] PULSE_LD = CNT_W'(PULSE_CYC - 1);
    localparam logic [4:0]       DIV_LD   = 5'(OSC_DIV_HALF - 1);
    localparam logic [4:0]       NP_CODE  = 5'(CODE_PULSES);
    localparam logic [4:0]       NP_EXTRA = 5'(EXTRA_PULSES);

    prog_state_t q;
    prog_state_t n;
    logic        cnt_done;
    logic [4:0]  np;

    always_comb begin
        n           = q;
        cnt_done    = (q.cnt == '0);
        n.rsp_valid = 1'b0;
        n.rd_s1     = LINK.code_data_port;
        n.rd_s2     = q.rd_s1;
        n.rst_lvl   = 1'b1;
        np          = (q.mode == MODE_PROG_CODE) ? NP_CODE : NP_EXTRA;

        // Device oscillator, 125 MHz divided by 24
        if (q.div == '0) begin
            n.div = DIV_LD;
            n.osc = ~q.osc;
        end else begin
            n.div = q.div - 5'h01;
        end

        if (!cnt_done) begin
            n.cnt = q.cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        end

        unique case (q.st)
            P_IDLE: begin
                n.program_store_enable_n_n  = 1'b1;
                n.strobe  = 1'b1;
                n.vpp     = VPP_HIGH;
                n.data_oe = 1'b0;
                n.sel     = SEL_IDLE;
                // Each location is its own command; back to back is allowed
                if (CMD_VALID && (CMD_MODE != MODE_NONE)) begin
                    n.mode   = CMD_MODE;
                    n.addr   = CMD_ADDR;
                    n.data   = CMD_DATA;
                    n.pulses = '0;
                    n.cnt    = SETUP_LD;
                    n.st     = P_ADDR;
                end
            end
            P_ADDR: begin
                if (cnt_done) begin
                    n.cnt = SETUP_LD;
                    if (is_write(q.mode)) begin
                        n.data_oe = 1'b1;
                        n.st      = P_DATA;
                    end else begin
                        n.sel    = sel_of(q.mode);
                        n.program_store_enable_n_n = 1'b0;
                        n.st     = P_READ;
                    end
                end
            end
            P_DATA: begin
                if (cnt_done) begin
                    n.sel    = sel_of(q.mode);
                    n.program_store_enable_n_n = 1'b0;
                    n.cnt    = SETUP_LD;
                    n.st     = P_SEL;
                end
            end
            P_SEL: begin
                if (cnt_done) begin
                    n.vpp = VPP_PROG;
                    n.cnt = VPPS_LD;
                    n.st  = P_VPPUP;
                end
            end
            P_VPPUP: begin
                if (cnt_done) begin
                    n.strobe = 1'b0;
                    n.cnt    = PULSE_LD;
                    n.st     = P_LOW;
                end
            end
            P_LOW: begin
                if (cnt_done) begin
                    n.strobe = 1'b1;
                    n.pulses = q.pulses + 5'h01;
                    n.cnt    = GAP_LD;
                    n.st     = P_HIGH;
                end
            end
            P_HIGH: begin
                if (cnt_done) begin
                    if (q.pulses == np) begin
                        n.vpp = VPP_HIGH;
                        n.cnt = VPPH_LD;
                        n.st  = P_VPPDN;
                    end else begin
                        n.strobe = 1'b0;
                        n.cnt    = PULSE_LD;
                        n.st     = P_LOW;
                    end
                end
            end
            P_VPPDN: begin
                if (cnt_done) begin
                    n.cnt = SETUP_LD;
                    n.st  = P_DONE;
                end
            end
            P_READ: begin
                // Device answer passes two sampling stages before capture
                if (cnt_done) begin
                    n.rsp_data = q.rd_s2;
                    n.cnt      = SETUP_LD;
                    n.st       = P_DONE;
                end
            end
            P_DONE: begin
                // Address and data held past the last pulse, then data and selects released; address stays driven
                if (cnt_done) begin
                    n.program_store_enable_n_n    = 1'b1;
                    n.data_oe   = 1'b0;
                    n.sel       = SEL_IDLE;
                    n.rsp_valid = 1'b1;
                    n.st        = P_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q        <= '0;
            q.st     <= P_IDLE;
            q.program_store_enable_n_n <= 1'b1;
            q.strobe <= 1'b1;
            q.vpp    <= VPP_HIGH;
            q.mode   <= MODE_NONE;
        end else begin
            q <= n;
        end
    end

    assign CMD_READY = (q.st == P_IDLE);
    assign BUSY      = (q.st != P_IDLE);
    assign RSP_VALID = q.rsp_valid;
    assign RSP_DATA  = q.rsp_data;

    assign LINK.osc_clk                 = q.osc;
    assign LINK.reset_level             = q.rst_lvl;
    assign LINK.program_store_enable_n  = q.program_store_enable_n_n;
    assign LINK.latch_strobe_prog_pulse = q.strobe;
    assign LINK.ext_access_prog_voltage = q.vpp;
    assign LINK.mode_select_a           = q.sel[4];
    assign LINK.mode_select_b           = q.sel[3];
    assign LINK.mode_select_c           = q.sel[2];
    assign LINK.mode_select_d           = q.sel[1];
    assign LINK.mode_select_e           = q.sel[0];
    assign LINK.low_address_port        = q.addr[LOW_ADDR_W-1:0];
    assign LINK.high_address_bits       = q.addr[ADDR_W-1:LOW_ADDR_W];
    assign LINK.prog_data               = q.data;
    assign LINK.prog_data_oe            = q.data_oe;
endmodule

/* File: verilog/pv_pkg.sv */
// Shared constants, types and mode tables for the EPROM program and verify link
package pv_pkg;
    localparam int          CLK_MHZ        = 125;
    localparam int          OSC_DIV_HALF   = 12;
    localparam int          OSC_TCLCL_CYC  = 2 * OSC_DIV_HALF;
    localparam int          OSC_MIN_MHZ    = 4;
    localparam int          OSC_MAX_MHZ    = 6;
    localparam int          SETUP_TCLCL    = 48;
    localparam int          SETUP_CYC      = SETUP_TCLCL * OSC_TCLCL_CYC;
    localparam int          VPP_SETUP_US   = 10;
    localparam int          VPP_SETUP_CYC  = VPP_SETUP_US * CLK_MHZ;
    localparam int          VPP_HOLD_US    = 10;
    localparam int          VPP_HOLD_CYC   = VPP_HOLD_US * CLK_MHZ;
    localparam int          PULSE_GAP_US   = 10;
    localparam int          PULSE_GAP_CYC  = PULSE_GAP_US * CLK_MHZ;
    localparam int          PULSE_US       = 100;
    localparam int          PULSE_CYC_DEF  = PULSE_US * CLK_MHZ;
    localparam int          CNT_W          = 14;
    localparam int          CODE_PULSES    = 5;
    localparam int          EXTRA_PULSES   = 25;
    localparam int          ADDR_W         = 14;
    localparam int          LOW_ADDR_W     = 8;
    localparam int          ENC_W          = 6;
    localparam int          LOCK_N         = 3;
    localparam logic [4:0]  SEL_IDLE       = 5'h00;
    localparam logic [4:0]  SEL_PROG_CODE  = 5'h0F;
    localparam logic [4:0]  SEL_VERIFY     = 5'h03;
    localparam logic [4:0]  SEL_PROG_ENC   = 5'h0D;
    localparam logic [4:0]  SEL_LOCK1      = 5'h1F;
    localparam logic [4:0]  SEL_LOCK2      = 5'h1C;
    localparam logic [4:0]  SEL_LOCK3      = 5'h16;
    localparam logic [4:0]  SEL_SIG        = 5'h00;
    localparam logic [13:0] SIG_ADDR0      = 14'h0030;
    localparam logic [13:0] SIG_ADDR1      = 14'h0031;
    localparam logic [13:0] SIG_ADDR2      = 14'h0060;
    localparam logic [7:0]  BYTE_ERASED    = 8'hFF;
    localparam logic [7:0]  BUS_IDLE       = 8'hFF;

    typedef enum logic [1:0] {VPP_LOW, VPP_HIGH, VPP_PROG} vpp_level_t;

    typedef enum logic [2:0] {
        MODE_NONE, MODE_PROG_CODE, MODE_VERIFY, MODE_PROG_ENC,
        MODE_LOCK1, MODE_LOCK2, MODE_LOCK3, MODE_SIG
    } pv_mode_t;

    typedef struct packed {
        logic        rst;
        logic        program_store_enable_n_n;
        logic        strobe;
        vpp_level_t  vpp;
        logic [4:0]  sel;
        logic [13:0] addr;
        logic [7:0]  data;
    } pin_t;

    function automatic logic [4:0] sel_of(input pv_mode_t m);
        unique case (m)
            MODE_PROG_CODE: sel_of = SEL_PROG_CODE;
            MODE_VERIFY:    sel_of = SEL_VERIFY;
            MODE_PROG_ENC:  sel_of = SEL_PROG_ENC;
            MODE_LOCK1:     sel_of = SEL_LOCK1;
            MODE_LOCK2:     sel_of = SEL_LOCK2;
            MODE_LOCK3:     sel_of = SEL_LOCK3;
            MODE_SIG:       sel_of = SEL_SIG;
            MODE_NONE:      sel_of = SEL_IDLE;
        endcase
    endfunction

    function automatic pv_mode_t mode_of(input logic [4:0] s);
        unique case (s)
            SEL_PROG_CODE: mode_of = MODE_PROG_CODE;
            SEL_VERIFY:    mode_of = MODE_VERIFY;
            SEL_PROG_ENC:  mode_of = MODE_PROG_ENC;
            SEL_LOCK1:     mode_of = MODE_LOCK1;
            SEL_LOCK2:     mode_of = MODE_LOCK2;
            SEL_LOCK3:     mode_of = MODE_LOCK3;
            SEL_SIG:       mode_of = MODE_SIG;
            default:       mode_of = MODE_NONE;
        endcase
    endfunction

    function automatic logic is_write(input pv_mode_t m);
        is_write = (m == MODE_PROG_CODE) || (m == MODE_PROG_ENC) || (m == MODE_LOCK1)
                || (m == MODE_LOCK2) || (m == MODE_LOCK3);
    endfunction
endpackage

/* File: verilog/pv_link_if.sv */
// Pin bundle between the external programmer and the device's programming port
interface pv_link_if;
    import pv_pkg::*;
    logic       osc_clk;
    logic       reset_level;
    logic       program_store_enable_n;
    logic       latch_strobe_prog_pulse;
    vpp_level_t ext_access_prog_voltage;
    logic       mode_select_a;
    logic       mode_select_b;
    logic       mode_select_c;
    logic       mode_select_d;
    logic       mode_select_e;
    logic [7:0] low_address_port;
    logic [5:0] high_address_bits;
    logic [7:0] prog_data;
    logic       prog_data_oe;
    logic [7:0] dev_data;
    logic       dev_data_oe;
    logic [7:0] code_data_port;

    // Wire level of the shared data port; pulled high when nobody drives
    assign code_data_port = dev_data_oe ? dev_data : (prog_data_oe ? prog_data : BUS_IDLE);

    modport programmer (
        output osc_clk, reset_level, program_store_enable_n, latch_strobe_prog_pulse,
        output ext_access_prog_voltage, mode_select_a, mode_select_b, mode_select_c,
        output mode_select_d, mode_select_e, low_address_port, high_address_bits,
        output prog_data, prog_data_oe,
        input  code_data_port
    );

    modport device (
        input  osc_clk, reset_level, program_store_enable_n, latch_strobe_prog_pulse,
        input  ext_access_prog_voltage, mode_select_a, mode_select_b, mode_select_c,
        input  mode_select_d, mode_select_e, low_address_port, high_address_bits,
        input  code_data_port,
        output dev_data, dev_data_oe
    );
endinterface

/* File: verilog/pv_device.sv */
// Device end: decodes programming pins, holds EPROM, encryption array and lock bits
module pv_device
    import pv_pkg::*;
#(
    parameter int         CODE_AW   = ADDR_W,
    parameter logic [7:0] SIG_BYTE0 = 8'hA5,  // Arbitrary value
    parameter logic [7:0] SIG_BYTE1 = 8'h3C,  // Arbitrary value
    parameter logic [7:0] SIG_BYTE2 = 8'h0E   // Arbitrary value
) (
    input  wire logic               CLK,
    input  wire logic               RESETN,
    pv_link_if.device               LINK,
    input  wire logic [CODE_AW-1:0] CODE_RD_ADDR,
    output logic      [7:0]         CODE_RD_DATA,
    output logic      [LOCK_N-1:0]  LOCK_BITS
);
    localparam int CODE_DEPTH = 1 << CODE_AW;
    localparam int ENC_DEPTH  = 1 << ENC_W;

    typedef struct packed {
        pin_t                             s1;
        pin_t                             s2;
        logic                             strobe_prev;
        logic [CODE_DEPTH-1:0][7:0]       code;
        logic [ENC_DEPTH-1:0][7:0]        enc;
        logic [LOCK_N-1:0]                lock;
        logic [7:0]                       dout;
        logic                             doe;
        logic [7:0]                       rd;
    } dev_state_t;

    dev_state_t             q;
    dev_state_t             n;
    pin_t                   pins;
    pin_t                   p;
    pv_mode_t               m;
    logic [CODE_AW-1:0]     a;
    logic [ENC_W-1:0]       ea;
    logic                   write_ok;
    logic                   read_ok;
    logic                   fall;
    logic [7:0]             sig;

    always_comb begin
        pins.rst    = LINK.reset_level;
        pins.program_store_enable_n_n = LINK.program_store_enable_n;
        pins.strobe = LINK.latch_strobe_prog_pulse;
        pins.vpp    = LINK.ext_access_prog_voltage;
        pins.sel    = {LINK.mode_select_a, LINK.mode_select_b, LINK.mode_select_c,
                       LINK.mode_select_d, LINK.mode_select_e};
        pins.addr   = {LINK.high_address_bits, LINK.low_address_port};
        pins.data   = LINK.code_data_port;
    end

    always_comb begin
        n        = q;
        n.s1     = pins;
        n.s2     = q.s1;
        p        = q.s2;
        m        = mode_of(p.sel);
        a        = p.addr[CODE_AW-1:0];
        ea       = p.addr[ENC_W-1:0];
        fall     = q.strobe_prev && !p.strobe;
        // Strobe counts only at programming voltage in a write mode
        write_ok = p.rst && !p.program_store_enable_n_n && (p.vpp == VPP_PROG) && is_write(m);
        read_ok  = p.rst && !p.program_store_enable_n_n && p.strobe && (p.vpp == VPP_HIGH)
                && ((m == MODE_VERIFY) || (m == MODE_SIG));
        n.strobe_prev = p.strobe;
        if (write_ok && fall) begin
            // Cells only go from one to zero, so repeated pulses are harmless
            unique case (m)
                MODE_PROG_CODE: n.code[a] = q.code[a] & p.data;
                MODE_PROG_ENC:  n.enc[ea] = q.enc[ea] & p.data;
                MODE_LOCK1:     n.lock[0] = 1'b0;
                MODE_LOCK2:     n.lock[1] = 1'b0;
                MODE_LOCK3:     n.lock[2] = 1'b0;
                default:        n.lock    = q.lock;
            endcase
        end
        unique case (p.addr)
            SIG_ADDR0: sig = SIG_BYTE0;
            SIG_ADDR1: sig = SIG_BYTE1;
            SIG_ADDR2: sig = SIG_BYTE2;
            default:   sig = BYTE_ERASED;
        endcase
        n.doe = read_ok;
        if (m == MODE_VERIFY) begin
            n.dout = ~(q.code[a] ^ q.enc[ea]);
        end else begin
            n.dout = sig;
        end
        n.rd = q.code[CODE_RD_ADDR];
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            q      <= '0;
            q.code <= '1;
            q.enc  <= '1;
            q.lock <= '1;
        end else begin
            q <= n;
        end
    end

    assign LINK.dev_data    = q.dout;
    assign LINK.dev_data_oe = q.doe;
    assign CODE_RD_DATA     = q.rd;
    assign LOCK_BITS        = q.lock;
endmodule

/* File: test/pv_link_chk.sv */
// Concurrent checks on the programming link between programmer and device
module pv_link_chk
    import pv_pkg::*;
#(
    parameter int unsigned PULSE_CYC = PULSE_CYC_DEF
) (
    input wire logic       CLK,
    input wire logic       RESETN,
    input wire logic       osc_clk,
    input wire logic       reset_level,
    input wire logic       program_store_enable_n,
    input wire logic       latch_strobe_prog_pulse,
    input wire vpp_level_t ext_access_prog_voltage,
    input wire logic       mode_select_a,
    input wire logic       mode_select_b,
    input wire logic       mode_select_c,
    input wire logic       mode_select_d,
    input wire logic       mode_select_e,
    input wire logic [7:0] low_address_port,
    input wire logic [5:0] high_address_bits,
    input wire logic       prog_data_oe,
    input wire logic       dev_data_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int OSC_LO = CLK_MHZ / OSC_MAX_MHZ;
    localparam int OSC_HI = CLK_MHZ / OSC_MIN_MHZ - 1;
    logic [4:0]  sel;
    logic        wr_sel;
    logic        rd_mode;
    logic        vpp_on;
    logic [31:0] vpp_cnt_r;
    logic [31:0] low_cnt_r;
    logic [5:0]  osc_cnt_r;
    logic        osc_seen_r;
    logic        osc_armed_r;
    logic [2:0]  rd_pipe_r;
    assign sel = {mode_select_a, mode_select_b, mode_select_c, mode_select_d, mode_select_e};
    assign wr_sel = sel inside {SEL_PROG_CODE, SEL_PROG_ENC, SEL_LOCK1, SEL_LOCK2, SEL_LOCK3};
    assign vpp_on = ext_access_prog_voltage == VPP_PROG;
    assign rd_mode = reset_level && !program_store_enable_n && latch_strobe_prog_pulse
        && ext_access_prog_voltage == VPP_HIGH && sel inside {SEL_VERIFY, SEL_SIG};
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            vpp_cnt_r <= 32'h0;
            low_cnt_r <= 32'h0;
            osc_cnt_r <= 6'h00;
            osc_seen_r <= 1'b0;
            osc_armed_r <= 1'b0;
            rd_pipe_r <= 3'h0;
        end else begin
            vpp_cnt_r <= vpp_on ? vpp_cnt_r + 32'h1 : 32'h0;
            low_cnt_r <= latch_strobe_prog_pulse ? 32'h0 : low_cnt_r + 32'h1;
            osc_cnt_r <= (osc_clk && !osc_seen_r) ? 6'h00 : osc_cnt_r + 6'h01;
            osc_seen_r <= osc_clk;
            // First rise after reset only arms the period check
            osc_armed_r <= osc_armed_r || (osc_clk && !osc_seen_r);
            // Read mode delayed by the device's two sync stages and output register
            rd_pipe_r <= {rd_pipe_r[1:0], rd_mode};
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_pulse_start;
        $fell(latch_strobe_prog_pulse);
    endsequence
    sequence s_pulse_end;
        $rose(latch_strobe_prog_pulse);
    endsequence
    sequence s_held;
        !program_store_enable_n ##1 !program_store_enable_n;
    endsequence
    a_vpp_context: assert property (vpp_on |-> !program_store_enable_n && reset_level && prog_data_oe)
        else $error("programming voltage outside an enabled write");
    a_vpp_write_sel: assert property (vpp_on |-> wr_sel)
        else $error("programming voltage with a non-write select");
    a_strobe_vpp: assert property (s_pulse_start |-> vpp_on && wr_sel)
        else $error("strobe pulsed without programming voltage");
    a_vpp_setup: assert property (s_pulse_start |-> vpp_cnt_r >= VPP_SETUP_CYC)
        else $error("programming voltage raised too late before strobe");
    a_pulse_width: assert property (s_pulse_end |-> low_cnt_r == PULSE_CYC)
        else $error("strobe pulse width wrong");
    a_vpp_after_pulse: assert property (s_pulse_end |-> vpp_on [*8])
        else $error("programming voltage dropped right after strobe");
    a_data_first: assert property ($fell(program_store_enable_n) && wr_sel |-> $past(prog_data_oe))
        else $error("select applied before data");
    a_addr_held: assert property (s_held |-> $stable({high_address_bits, low_address_port}))
        else $error("address moved during a command");
    a_read_drive: assert property (dev_data_oe == rd_pipe_r[2])
        else $error("device data drive not tied to read mode");
    a_no_contention: assert property (!(dev_data_oe && prog_data_oe))
        else $error("both ends drive the data port");
    a_osc_range: assert property (osc_clk && !osc_seen_r && osc_armed_r |->
        osc_cnt_r >= OSC_LO && osc_cnt_r <= OSC_HI)
        else $error("oscillator period out of range");
endmodule

/* File: test/testbench.sv */
// Self-checking bench: programmer and device joined over the link
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import pv_pkg::*;
    localparam logic [7:0] SIG0 = 8'h6B;  // Arbitrary value
    localparam logic [7:0] SIG1 = 8'h9D;  // Arbitrary value
    localparam logic [7:0] SIG2 = 8'h41;  // Arbitrary value
    typedef struct {pv_mode_t m; logic [13:0] a; logic [7:0] d; logic [7:0] e; int p;} row_t;
    row_t rows[8] = '{
        '{MODE_PROG_CODE, 14'h2A55, 8'h3C, 8'h00, 5},
        '{MODE_VERIFY, 14'h2A55, 8'h00, 8'h3C, 0},
        '{MODE_SIG, SIG_ADDR0, 8'h00, SIG0, 0},
        '{MODE_SIG, SIG_ADDR2, 8'h00, SIG2, 0},
        '{MODE_SIG, 14'h0032, 8'h00, 8'hFF, 0},
        '{MODE_PROG_ENC, 14'h0015, 8'h0F, 8'h00, 25},
        '{MODE_VERIFY, 14'h2A55, 8'h00, 8'hCC, 0},
        '{MODE_LOCK1, 14'h0000, 8'h00, 8'h00, 25}};
    logic        clk;
    logic        resetn;
    logic        cmd_valid;
    logic        cmd_ready;
    pv_mode_t    cmd_mode;
    logic [13:0] cmd_addr;
    logic [7:0]  cmd_data;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic        busy;
    logic [13:0] code_rd_addr;
    logic [7:0]  code_rd_data;
    logic [2:0]  lock_bits;
    logic [13:0] wire_a;
    logic [7:0]  wire_d;
    int          n_fail;
    int          n_checks;
    int          n_pulse;
    pv_link_if pv_link_if_i ();
    pv_programmer #(.PULSE_CYC(20)) pv_programmer_i (.CLK(clk), .RESETN(resetn),
        .LINK(pv_link_if_i.programmer), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready),
        .CMD_MODE(cmd_mode), .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data),
        .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data), .BUSY(busy));
    pv_device #(.SIG_BYTE0(SIG0), .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) pv_device_i (
        .CLK(clk), .RESETN(resetn), .LINK(pv_link_if_i.device), .CODE_RD_ADDR(code_rd_addr),
        .CODE_RD_DATA(code_rd_data), .LOCK_BITS(lock_bits));
    pv_link_chk #(.PULSE_CYC(20)) pv_link_chk_i (.CLK(clk), .RESETN(resetn),
        .osc_clk(pv_link_if_i.osc_clk), .reset_level(pv_link_if_i.reset_level),
        .program_store_enable_n(pv_link_if_i.program_store_enable_n),
        .latch_strobe_prog_pulse(pv_link_if_i.latch_strobe_prog_pulse),
        .ext_access_prog_voltage(pv_link_if_i.ext_access_prog_voltage),
        .mode_select_a(pv_link_if_i.mode_select_a), .mode_select_b(pv_link_if_i.mode_select_b),
        .mode_select_c(pv_link_if_i.mode_select_c), .mode_select_d(pv_link_if_i.mode_select_d),
        .mode_select_e(pv_link_if_i.mode_select_e),
        .low_address_port(pv_link_if_i.low_address_port),
        .high_address_bits(pv_link_if_i.high_address_bits),
        .prog_data_oe(pv_link_if_i.prog_data_oe), .dev_data_oe(pv_link_if_i.dev_data_oe));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(negedge pv_link_if_i.latch_strobe_prog_pulse) begin
        n_pulse = n_pulse + 1;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Issue one command and follow the link until the response
    task automatic run_cmd(input pv_mode_t m, input logic [13:0] a, input logic [7:0] d);
        int w;
        n_pulse = 0;
        w = 0;
        while (cmd_ready !== 1'b1) @(negedge clk);
        cmd_mode = m;
        cmd_addr = a;
        cmd_data = d;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && w < 60000) begin
            if (pv_link_if_i.program_store_enable_n === 1'b0) begin
                wire_a = {pv_link_if_i.high_address_bits, pv_link_if_i.low_address_port};
            end
            if (pv_link_if_i.prog_data_oe === 1'b1) begin
                wire_d = pv_link_if_i.code_data_port;
            end
            @(negedge clk);
            w = w + 1;
        end
        check(rsp_valid, 1'b1);
    endtask
    initial begin
        resetn = 1'b0;
        cmd_valid = 1'b0;
        cmd_mode = MODE_NONE;
        cmd_addr = 14'h0000;
        cmd_data = 8'h00;
        code_rd_addr = 14'h2A55;
        n_fail = 0;
        n_checks = 0;
        n_pulse = 0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check(pv_link_if_i.latch_strobe_prog_pulse, 1'b1);
        check(pv_link_if_i.ext_access_prog_voltage, VPP_HIGH);
        resetn = 1'b1;
        @(negedge clk);
        check(pv_link_if_i.reset_level, 1'b1);
        check(lock_bits, 3'h7);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            run_cmd(rows[i].m, rows[i].a, rows[i].d);
            check(wire_a, rows[i].a);
            check(n_pulse, rows[i].p);
            if (rows[i].p == 0) begin
                check(rsp_data, rows[i].e);
            end else begin
                check(wire_d, rows[i].d);
            end
            $display("row %0d done", i);
        end
        repeat (2) @(negedge clk);
        check(code_rd_data, 8'h3C);
        check(lock_bits, 3'h6);
        $display("store test done");
        // Lock bit two command cut by reset after selects, before the voltage
        n_pulse = 0;
        cmd_mode = MODE_LOCK2;
        cmd_addr = 14'h0100;
        cmd_valid = 1'b1;
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (3000) @(negedge clk);
        check(busy, 1'b1);
        check({pv_link_if_i.mode_select_a, pv_link_if_i.mode_select_b,
               pv_link_if_i.mode_select_c, pv_link_if_i.mode_select_d,
               pv_link_if_i.mode_select_e}, SEL_LOCK2);
        check(pv_link_if_i.ext_access_prog_voltage, VPP_HIGH);
        check(lock_bits, 3'h6);
        resetn = 1'b0;
        @(negedge clk);
        check(pv_link_if_i.ext_access_prog_voltage, VPP_HIGH);
        resetn = 1'b1;
        code_rd_addr = 14'h0100;
        repeat (3) @(negedge clk);
        check(code_rd_data, BYTE_ERASED);
        check(busy, 1'b0);
        check(cmd_ready, 1'b1);
        check(pv_link_if_i.prog_data_oe, 1'b0);
        check(n_pulse, 0);
        $display("abort test done");
        complete_run();
    end
    initial begin
        repeat (125000) @(posedge clk);
        n_fail = n_fail + 1;
        complete_run();
    end
endmodule
